// >>> ict_pkg.sv
// Purpose: Shared constants and types for the instruction cycle timing block
// Assumes: Four-clock bus cycles with no wait states as the base figure
// Notes:   Cycle figures are external clock periods with read/write counts
package ict_pkg;

  // ----------------------------------------------------------------------
  // Effective address modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP, EA_INDEX,
    EA_ABS_W, EA_ABS_L, EA_PC_DISP, EA_PC_INDEX, EA_IMM
  } ict_ea_t;

  // ----------------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_MOVE, OP_ADD_REG, OP_ADD_MEM, xor_logical_op, OP_XOR_MEM,
    signed_divide_op, unsigned_divide_op, signed_multiply_op,
    unsigned_multiply_op, immediate_sum_op, operand_zeroing_op
  } ict_op_t;

  localparam int unsigned BUS_CYCLE_CLKS = 4;
  localparam logic [7:0]  CLK_SHORT_EXTRA = 8'h04;
  localparam logic [7:0]  CLK_REG_BW      = 8'h04;
  localparam logic [7:0]  CLK_REG_L       = 8'h06;
  localparam logic [7:0]  CLK_REG_L_RD    = 8'h08;
  localparam logic [7:0]  CLK_MEM_BW      = 8'h08;
  localparam logic [7:0]  CLK_MEM_L       = 8'h0C;
  localparam logic [7:0]  CLK_XOR_L       = 8'h08;
  localparam logic [7:0]  CLK_IMM_BW      = 8'h08;
  localparam logic [7:0]  CLK_IMM_L       = 8'h10;
  localparam logic [7:0]  CLK_SDIV        = 8'h9E;
  localparam logic [7:0]  CLK_UDIV        = 8'h8C;
  localparam logic [7:0]  CLK_MUL_BASE    = 8'h26;
  localparam logic [7:0]  CLK_PREDEC_BW   = 8'h06;
  localparam logic [7:0]  CLK_DISP_BW     = 8'h08;
  localparam logic [7:0]  CLK_INDEX_BW    = 8'h0A;
  localparam logic [7:0]  CLK_ABSL_BW     = 8'h0C;
  localparam logic [7:0]  CLK_IND_BW      = 8'h04;

endpackage

// >>> ict_req_if.sv
// Purpose: Carrier between the timing top and its effective address table
// Assumes: Same clock for both ends
// Notes:   Pure combinational lookup request and answer
`timescale 1ns/1ns
`default_nettype none
interface ict_req_if;
  import ict_pkg::*;
  ict_ea_t    mode;
  logic       is_long;
  logic [7:0] clks;
  logic [3:0] reads;
  modport master (output mode, output is_long, input clks, input reads);
  modport table_side (input mode, input is_long, output clks, output reads);
endinterface
`default_nettype wire

// >>> ict_ea_cost.sv
// Purpose: Effective address cost lookup (clocks and reads)
// Assumes: No wait states
// Notes:   Never produces write cycles
`timescale 1ns/1ns
`default_nettype none
module ict_ea_cost
  import ict_pkg::*;
(
  ict_req_if.table_side req   // Mode in, cost out
);
  logic [7:0] base_c;
  logic [3:0] base_r;

  always_comb begin
    base_c = 8'h00;
    base_r = 4'h0;
    unique case (req.mode)
      EA_DREG, EA_AREG: begin
        base_c = 8'h00;
        base_r = 4'h0;
      end
      EA_IND, EA_POSTINC, EA_IMM: begin
        base_c = CLK_IND_BW;
        base_r = 4'h1;
      end
      EA_PREDEC: begin
        base_c = CLK_PREDEC_BW;
        base_r = 4'h1;
      end
      EA_DISP, EA_ABS_W, EA_PC_DISP: begin
        base_c = CLK_DISP_BW;
        base_r = 4'h2;
      end
      // Index register size does not matter
      EA_INDEX, EA_PC_INDEX: begin
        base_c = CLK_INDEX_BW;
        base_r = 4'h2;
      end
      EA_ABS_L: begin
        base_c = CLK_ABSL_BW;
        base_r = 4'h3;
      end
      default: begin
        base_c = 8'h00;
        base_r = 4'h0;
      end
    endcase
  end

  // Long adds one read and four clocks unless register direct
  always_comb begin
    if (req.is_long && base_r != 4'h0) begin
      req.clks  = base_c + CLK_SHORT_EXTRA;
      req.reads = base_r + 4'h1;
    end else begin
      req.clks  = base_c;
      req.reads = base_r;
    end
  end
endmodule
`default_nettype wire

// >>> ict_timing.sv
// Purpose: Per-instruction cycle sequencer with bus read/write accounting
// Assumes: Decoder gives class, size, source and destination modes
// Notes:   Result pulses DONE_OUT when the final clock period ends
// Notes on behaviour
// - Every bus cycle spans four clocks; wait states add to the total.
// - Address evaluation covers extension fetch and operand read, never writes.
// - Register direct free; indirect 4(1)/8(2); predecrement 6(1)/10(2).
// - Displacement, short, PC displacement 8(2); absolute long 12(3); long adds 4(1).
// - Indexed modes 10(2) or 14(3), independent of index size.
// - Register moves 4(1); data register to indirect 8(1/1).
// - Long moves to memory write twice; 12(1/2) to indirect, 20(5/0) absolute long source.
// - Standard times include execute, store, prefetch; add address cost where marked.
// - Long add/sub/and/or to register base 6(1), or 8 for direct/immediate.
// - Signed divide at most 158, unsigned at most 140, spread under ten percent.
// - Multiply takes 38+2n, n from ones or bit-pair transitions.
// - Xor to data register only from data register; 4 or 8 clocks.
// - Immediate add to data register 8(2) or 16(3), including extension words.
// - Single operand 4 or 6 on registers, 12(1/2) long memory plus address.
`timescale 1ns/1ns
`default_nettype none
module ict_timing
  import ict_pkg::*;
(
  input  wire logic             CLK_SYS_IN,      // 125 MHz system clock
  input  wire logic             NRST_IN,         // Synchronous reset, active low
  input  wire logic             START_IN,        // Start one instruction
  input  wire ict_pkg::ict_op_t OP_IN,           // Instruction class
  input  wire logic             LONG_IN,         // Long operand size
  input  wire ict_pkg::ict_ea_t SRC_IN,          // Source mode
  input  wire ict_pkg::ict_ea_t DST_IN,          // Destination mode
  input  wire logic [15:0]      MUL_SRC_IN,      // Multiply source value
  input  wire logic             BUS_WAIT_IN,     // Wait state request (async)
  output logic                  BUSY_OUT,        // Instruction in progress
  output logic                  DONE_OUT,        // One-cycle completion pulse
  output logic                  ILLEGAL_OUT,     // Illegal source mode flagged
  output logic [9:0]            CLKS_OUT,        // Total periods incl. waits
  output logic [3:0]            READS_OUT,       // Bus read count
  output logic [3:0]            WRITES_OUT       // Bus write count
);
  import ict_pkg::*;

  // ----------------------------------------------------------------------
  // Source cost lookup
  // ----------------------------------------------------------------------
  ict_req_if ea_if ();
  assign ea_if.mode    = SRC_IN;
  assign ea_if.is_long = LONG_IN;
  ict_ea_cost u_ea (.req(ea_if.table_side));

  // ----------------------------------------------------------------------
  // Destination cost lookup
  // ----------------------------------------------------------------------
  // Word figures only; the long store is added in the table below.
  // Predecrement costs as plain indirect: the write needs no extra step.
  ict_req_if dst_if ();
  assign dst_if.mode    = (DST_IN == EA_PREDEC) ? EA_IND : DST_IN;
  assign dst_if.is_long = 1'b0;
  ict_ea_cost u_dst (.req(dst_if.table_side));

  // ----------------------------------------------------------------------
  // Wait input synchroniser
  // ----------------------------------------------------------------------
  logic wait_s1_q;
  logic wait_s2_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
    end else begin
      wait_s1_q <= BUS_WAIT_IN;
      wait_s2_q <= wait_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Multiply n count
  // ----------------------------------------------------------------------
  logic [4:0]  mul_n;
  logic [16:0] ext_src;
  always_comb begin
    mul_n   = 5'h00;
    ext_src = {MUL_SRC_IN, 1'b0};
    for (int i = 0; i < 16; i++) begin
      if (OP_IN == signed_multiply_op)
        mul_n = mul_n + 5'(ext_src[i+1] ^ ext_src[i]);
      else
        mul_n = mul_n + 5'(MUL_SRC_IN[i]);
    end
  end

  // ----------------------------------------------------------------------
  // Instruction cost table
  // ----------------------------------------------------------------------
  logic [7:0] base_c;
  logic [3:0] base_r;
  logic [3:0] base_w;
  logic       add_ea;
  logic       illegal;
  logic       src_direct;
  logic       dst_mem;
  assign src_direct = (SRC_IN == EA_DREG) || (SRC_IN == EA_AREG) || (SRC_IN == EA_IMM);
  assign dst_mem    = !((DST_IN == EA_DREG) || (DST_IN == EA_AREG));

  always_comb begin
    base_c  = CLK_REG_BW;
    base_r  = 4'h1;
    base_w  = 4'h0;
    add_ea  = 1'b1;
    illegal = 1'b0;
    unique case (OP_IN)
      OP_MOVE: begin
        // Fetch plus destination address cost; source added from lookup
        if (!dst_mem) begin
          base_c = CLK_REG_BW;
          base_w = 4'h0;
        end else begin
          // Destination reads already hold the opcode fetch
          base_c = CLK_REG_BW + dst_if.clks + (LONG_IN ? CLK_SHORT_EXTRA : 8'h00);
          base_r = dst_if.reads;
          base_w = LONG_IN ? 4'h2 : 4'h1;
        end
      end
      OP_ADD_REG: begin
        if (LONG_IN)
          base_c = src_direct ? CLK_REG_L_RD : CLK_REG_L;
        else
          base_c = CLK_REG_BW;
      end
      OP_ADD_MEM, OP_XOR_MEM, operand_zeroing_op: begin
        if (!dst_mem) begin
          base_c = LONG_IN ? CLK_REG_L : CLK_REG_BW;
          add_ea = 1'b0;
        end else begin
          base_c = LONG_IN ? CLK_MEM_L : CLK_MEM_BW;
          base_w = LONG_IN ? 4'h2 : 4'h1;
        end
      end
      xor_logical_op: begin
        base_c  = LONG_IN ? CLK_XOR_L : CLK_REG_BW;
        add_ea  = 1'b0;
        illegal = (SRC_IN != EA_DREG);
      end
      signed_divide_op: begin
        base_c = CLK_SDIV;
      end
      unsigned_divide_op: begin
        base_c = CLK_UDIV;
      end
      signed_multiply_op, unsigned_multiply_op: begin
        base_c = CLK_MUL_BASE + {2'b00, mul_n, 1'b0};
      end
      immediate_sum_op: begin
        base_c = LONG_IN ? CLK_IMM_L : CLK_IMM_BW;
        base_r = LONG_IN ? 4'h3 : 4'h2;
        add_ea = 1'b0;
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
  end

  logic [7:0] tot_c;
  logic [3:0] tot_r;
  // Address cost contributes clocks and reads, never writes
  assign tot_c = base_c + (add_ea ? ea_if.clks : 8'h00);
  assign tot_r = base_r + (add_ea ? ea_if.reads : 4'h0);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} ict_state_t;
  ict_state_t state_q;
  logic [9:0] remain_q;
  logic [9:0] waits_q;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      state_q  <= ST_IDLE;
      remain_q <= 10'h000;
      waits_q  <= 10'h000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (START_IN) begin
            state_q  <= ST_RUN;
            remain_q <= {2'b00, tot_c};
            waits_q  <= 10'h000;
          end
        end
        ST_RUN: begin
          // Wait states stretch the run one period each
          if (wait_s2_q) begin
            waits_q <= waits_q + 10'h001;
          end else if (remain_q <= 10'h001) begin
            state_q <= ST_DONE;
          end else begin
            remain_q <= remain_q - 10'h001;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Run length monitor
  // ----------------------------------------------------------------------
  // Counts the periods really spent running, waits included, so the
  // reported total can be held against the sequencer's own behaviour
  logic [9:0] run_cyc_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      run_cyc_q <= 10'h000;
    end else if (state_q == ST_IDLE && START_IN) begin
      run_cyc_q <= 10'h000;
    end else if (state_q == ST_RUN) begin
      run_cyc_q <= run_cyc_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  logic [7:0] lat_c_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      lat_c_q     <= 8'h00;
      READS_OUT   <= 4'h0;
      WRITES_OUT  <= 4'h0;
      ILLEGAL_OUT <= 1'b0;
    end else if (state_q == ST_IDLE && START_IN) begin
      lat_c_q     <= tot_c;
      READS_OUT   <= tot_r;
      WRITES_OUT  <= base_w;
      ILLEGAL_OUT <= illegal;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      CLKS_OUT <= 10'h000;
    end else begin
      BUSY_OUT <= (state_q == ST_IDLE) ? START_IN : (state_q == ST_RUN);
      DONE_OUT <= (state_q == ST_RUN) && !wait_s2_q && (remain_q <= 10'h001);
      if (state_q == ST_RUN && !wait_s2_q && remain_q <= 10'h001)
        CLKS_OUT <= {2'b00, lat_c_q} + waits_q;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_div_signed: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    OP_IN == signed_divide_op |-> base_c == 8'h9E) else $error("signed divide base wrong");
  chk_div_unsigned: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    OP_IN == unsigned_divide_op |-> base_c == 8'h8C) else $error("unsigned divide base");
  chk_mul_time: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == unsigned_multiply_op && MUL_SRC_IN == 16'hFFFF) |-> base_c == 8'h46)
    else $error("multiply worst case wrong");
  chk_ea_nowrite: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    !dst_mem |-> base_w == 4'h0) else $error("address cost wrote");
  chk_xor_source: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == xor_logical_op && SRC_IN != EA_DREG) |-> illegal) else $error("xor source");
  chk_imm_long: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == immediate_sum_op && LONG_IN) |-> tot_c == 8'h10 && tot_r == 4'h3)
    else $error("immediate long cost");
  chk_move_abs: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == OP_MOVE && LONG_IN && SRC_IN == EA_ABS_L && DST_IN == EA_DREG)
    |-> tot_c == 8'h14 && tot_r == 4'h5) else $error("long move abs cost");
  chk_move_ind: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == OP_MOVE && !LONG_IN && SRC_IN == EA_DREG && DST_IN == EA_IND)
    |-> tot_c == 8'h08 && tot_r == 4'h1 && base_w == 4'h1) else $error("move ind cost");
  chk_long_base: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == OP_ADD_REG && LONG_IN && SRC_IN == EA_IND) |-> base_c == 8'h06)
    else $error("long base wrong");
  chk_done_time: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    DONE_OUT |-> CLKS_OUT == run_cyc_q)
    else $error("reported total differs from run length");
  chk_move_long_ind: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == OP_MOVE && LONG_IN && SRC_IN == EA_DREG && DST_IN == EA_IND)
    |-> tot_c == 8'h0C && tot_r == 4'h1 && base_w == 4'h2) else $error("long move ind cost");
  chk_clr_long_reg: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == operand_zeroing_op && LONG_IN && DST_IN == EA_DREG)
    |-> tot_c == 8'h06 && tot_r == 4'h1 && base_w == 4'h0) else $error("long clear reg cost");
  chk_predec_long: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == OP_ADD_REG && LONG_IN && SRC_IN == EA_PREDEC)
    |-> tot_c == 8'h10 && tot_r == 4'h3) else $error("long predecrement cost");
  chk_index_long: assert property (@(posedge CLK_SYS_IN) disable iff (!NRST_IN)
    (OP_IN == OP_MOVE && LONG_IN && SRC_IN == EA_INDEX && DST_IN == EA_DREG)
    |-> tot_c == 8'h12 && tot_r == 4'h4) else $error("long indexed cost");
  cov_move: cover property (@(posedge CLK_SYS_IN) DONE_OUT && WRITES_OUT == 4'h2);
  cov_wait: cover property (@(posedge CLK_SYS_IN) state_q == ST_RUN && wait_s2_q);
  cov_div:  cover property (@(posedge CLK_SYS_IN) START_IN && OP_IN == signed_divide_op);
  cov_ill:  cover property (@(posedge CLK_SYS_IN) DONE_OUT && ILLEGAL_OUT);
endmodule
`default_nettype wire

// >>> ict_mem_model.sv
// Purpose: Far-side memory model that stretches bus cycles with wait states
// Assumes: One wait request period per stalled clock
// Notes:   Idle level low; stall count taken three falling edges after go rises
`timescale 1ns/1ns
`default_nettype none
module ict_mem_model (
  input  wire logic       clk_in,   // System clock
  input  wire logic       go_in,    // Instruction issued
  input  wire logic [3:0] stall_in, // Wait periods to insert
  output logic            wait_out  // Wait state request
);
  initial begin
    wait_out = 1'b0;
    forever begin
      @(posedge go_in);
      // Late start so the stall lands inside the instruction
      repeat (3) @(negedge clk_in);
      repeat (stall_in) begin
        wait_out = 1'b1;
        @(negedge clk_in);
      end
      wait_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> instruction_cycle_timing_tb.sv
// Purpose: Self-checking bench for the instruction cycle sequencer
// Assumes: Fixed seed, inputs driven on the falling edge
// Notes:   Divide time checked as a window, everything else exact
`timescale 1ns/1ns
`default_nettype none
module instruction_cycle_timing_tb;
  import ict_pkg::*;
  typedef struct packed {
    logic [9:0] c;
    logic [3:0] r;
    logic [3:0] w;
    logic       ill;
  } ict_exp_t;
  logic        clk, nrst, start, lng, bwait, busy, done, ill, go;
  ict_op_t     op, ro;
  ict_ea_t     src, dst, rs;
  logic [15:0] mul;
  logic [3:0]  stall, rds, wrs;
  logic [9:0]  clks;
  logic [31:0] r;
  int          mismatches = 0;
  int          num_checks = 0;
  int          seed = 77830;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ict_timing i_ict_timing (.CLK_SYS_IN(clk), .NRST_IN(nrst), .START_IN(start), .OP_IN(op),
    .LONG_IN(lng), .SRC_IN(src), .DST_IN(dst), .MUL_SRC_IN(mul), .BUS_WAIT_IN(bwait),
    .BUSY_OUT(busy), .DONE_OUT(done), .ILLEGAL_OUT(ill), .CLKS_OUT(clks), .READS_OUT(rds),
    .WRITES_OUT(wrs));
  ict_mem_model i_ict_mem_model (.clk_in(clk), .go_in(go), .stall_in(stall), .wait_out(bwait));

  // ----------------------------------------------------------------------
  // Expected figures
  // ----------------------------------------------------------------------
  function automatic logic [13:0] ea_cost(input ict_ea_t m, input logic l);
    logic [9:0] c;
    logic [3:0] n;
    case (m)
      EA_IND, EA_POSTINC, EA_IMM: begin c = 10'h004; n = 4'h1; end
      EA_PREDEC: begin c = 10'h006; n = 4'h1; end
      EA_DISP, EA_ABS_W, EA_PC_DISP: begin c = 10'h008; n = 4'h2; end
      EA_INDEX, EA_PC_INDEX: begin c = 10'h00A; n = 4'h2; end
      EA_ABS_L: begin c = 10'h00C; n = 4'h3; end
      default: begin c = 10'h000; n = 4'h0; end
    endcase
    // Long operands cost one more word read
    if (l && c != 10'h000) begin c = c + 10'h004; n = n + 4'h1; end
    return {c, n};
  endfunction

  function automatic ict_exp_t expect_of(input ict_op_t o, input logic l, input ict_ea_t s,
                                         input ict_ea_t d, input logic [15:0] m);
    ict_exp_t    e;
    logic [13:0] es, ed;
    logic [15:0] x;
    e = '0;
    es = ea_cost(s, l);
    ed = ea_cost(d, l);
    x = (o == signed_multiply_op) ? (m ^ {m[14:0], 1'b0}) : m;
    e.r = 4'h1 + es[3:0];
    case (o)
      OP_MOVE: begin
        // Predecrement destination costs the same as plain indirect
        ed = ea_cost((d == EA_PREDEC) ? EA_IND : d, 1'b0);
        e.c = (ed[13:4] == 10'h000) ? 10'h004 : 10'h004 + ed[13:4] + (l ? 10'h004 : 10'h000);
        e.r = ((ed[3:0] == 4'h0) ? 4'h1 : ed[3:0]) + es[3:0];
        e.w = (ed[13:4] == 10'h000) ? 4'h0 : (l ? 4'h2 : 4'h1);
        e.c = e.c + es[13:4];
      end
      OP_ADD_REG: e.c = (!l ? 10'h004 : (s inside {EA_DREG, EA_AREG, EA_IMM}) ? 10'h008
                         : 10'h006) + es[13:4];
      xor_logical_op: begin e.c = l ? 10'h008 : 10'h004; e.r = 4'h1; e.ill = s != EA_DREG; end
      signed_divide_op: e.c = 10'h09E + es[13:4];
      unsigned_divide_op: e.c = 10'h08C + es[13:4];
      signed_multiply_op, unsigned_multiply_op:
        e.c = 10'h026 + 10'($countones(x)) * 10'h002 + es[13:4];
      immediate_sum_op: begin e.c = l ? 10'h010 : 10'h008; e.r = l ? 4'h3 : 4'h2; end
      operand_zeroing_op, OP_ADD_MEM, OP_XOR_MEM: begin
        e.c = (d inside {EA_DREG, EA_AREG}) ? (l ? 10'h006 : 10'h004)
            : (l ? 10'h00C : 10'h008) + ed[13:4];
        e.r = 4'h1 + ed[3:0];
        e.w = (d inside {EA_DREG, EA_AREG}) ? 4'h0 : (l ? 4'h2 : 4'h1);
      end
      default: e.c = 10'h000;
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------------
  // Compare and run tasks
  // ----------------------------------------------------------------------
  task automatic cmp_num(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_range(input logic [9:0] got, input logic [9:0] lo, input logic [9:0] hi);
    num_checks++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic run(input ict_op_t o, input logic l, input ict_ea_t s, input ict_ea_t d,
                     input logic [15:0] m, input logic [3:0] st, input logic poke);
    ict_exp_t e;
    int       k;
    e = expect_of(o, l, s, d, m);
    e.c = e.c + {6'h00, st};
    @(negedge clk);
    op = o;
    lng = l;
    src = s;
    dst = d;
    mul = m;
    stall = st;
    start = 1'b1;
    go = 1'b1;
    @(negedge clk);
    start = 1'b0;
    go = 1'b0;
    if (poke) begin
      // A start while busy must be ignored
      repeat (4) @(negedge clk);
      op = operand_zeroing_op;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
    end
    k = 0;
    while (done !== 1'b1 && k < 600) begin
      @(posedge clk);
      #1;
      k++;
    end
    cmp_num({9'h000, done}, 10'h001);
    cmp_num({9'h000, ill}, {9'h000, e.ill});
    if (!e.ill) begin
      cmp_num({6'h00, rds}, {6'h00, e.r});
      cmp_num({6'h00, wrs}, {6'h00, e.w});
      if (o inside {signed_divide_op, unsigned_divide_op})
        cmp_range(clks, e.c - ((o == signed_divide_op) ? 10'h00F : 10'h00D), e.c);
      else
        cmp_num(clks, e.c);
    end
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {nrst, start, go, lng, mul, stall} = '0;
    op = OP_MOVE;
    src = EA_DREG;
    dst = EA_DREG;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    cmp_num({busy, done, rds, wrs}, 10'h000);
    for (int i = 0; i < 24; i++) begin
      run(OP_MOVE, i[0], ict_ea_t'(i[4:1] % 4'hC), EA_DREG, 16'h0000, 4'h0, 1'b0);
      run(OP_ADD_REG, 1'b1, ict_ea_t'(i[4:1] % 4'hC), EA_DREG, 16'h0000, 4'h0, 1'b0);
    end
    for (int i = 0; i < 18; i++) begin
      run(OP_MOVE, i[0], EA_DREG, ict_ea_t'(i[4:1]), 16'h0000, 4'h0, 1'b0);
      run(operand_zeroing_op, i[0], ict_ea_t'(i[4:1]), ict_ea_t'(i[4:1]), 16'h0000, 4'h0,
          1'b0);
      run(immediate_sum_op, i[0], EA_IMM, EA_DREG, 16'h0000, 4'h0, 1'b0);
      run(xor_logical_op, i[0], ict_ea_t'(i[4:1]), EA_DREG, 16'h0000, 4'h0, 1'b0);
      run((i % 3 == 0) ? OP_XOR_MEM : OP_ADD_MEM, i[0], ict_ea_t'(i[4:1]), ict_ea_t'(i[4:1]),
          16'h0000, 4'h0, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      mul = (i == 0) ? 16'h5555 : (i == 1) ? 16'h0000 : (i == 2) ? 16'hFFFF : 16'h8001;
      run(signed_multiply_op, 1'b0, EA_DREG, EA_DREG, mul, 4'h0, 1'b0);
      run(unsigned_multiply_op, 1'b0, EA_IND, EA_DREG, mul, 4'h0, 1'b0);
    end
    run(signed_divide_op, 1'b0, EA_DREG, EA_DREG, 16'h0000, 4'h0, 1'b1);
    run(unsigned_divide_op, 1'b0, EA_ABS_L, EA_DREG, 16'h0000, 4'h7, 1'b0);
    run(OP_MOVE, 1'b1, EA_ABS_L, EA_DREG, 16'h0000, 4'h3, 1'b0);
    repeat (80) begin
      r = $random(seed);
      ro = (r[1:0] == 2'h0) ? OP_MOVE : (r[1:0] == 2'h1) ? OP_ADD_REG
         : (r[1:0] == 2'h2) ? unsigned_multiply_op : signed_multiply_op;
      rs = ict_ea_t'(r[7:4] % 4'hC);
      if (ro != OP_MOVE && rs == EA_AREG) rs = EA_DREG;
      run(ro, r[2] & (ro inside {OP_MOVE, OP_ADD_REG}), rs,
          ict_ea_t'((ro == OP_MOVE) ? r[11:8] % 4'h9 : 4'h0), r[31:16], 4'h0, 1'b0);
    end
    results();
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
